// ### design/ddc_pkg.sv
// Constants shared by the downconverter input stage and its channel
// front ends. Assumes a 32-bit APB register bus and one sample clock.
package ddc_pkg;
	localparam int NUM_CH = 4;
	localparam int NUM_BUS = 4;
	localparam int BUS_W = 17;
	localparam int SAMP_W = 16;
	localparam int NCO_W = 32;
	localparam int MIX_W = 24;
	localparam int ACC_W = 70;
	localparam int OUT_W = 24;
	localparam int MAX_ORDER = 5;
	localparam int DECIM_W = 17;
	localparam int HIST_W = 7;
	// Register byte offsets
	localparam logic [11:0] OFS_TEST = 12'h000;
	localparam logic [11:0] OFS_LVL_CFG = 12'h004;
	localparam logic [11:0] OFS_LVL_PEAK = 12'h008;
	localparam logic [5:0] CH_BLOCK = 6'h01;
	localparam logic [3:0] OFS_CH_CFG = 4'h0;
	localparam logic [3:0] OFS_CH_FREQ = 4'h4;
	localparam logic [3:0] OFS_CH_DECIM = 4'h8;
	localparam logic [3:0] OFS_CH_STAT = 4'hc;
	// Channel config fields
	localparam int CFG_SRC_LSB = 0;
	localparam int CFG_INTERP_BIT = 3;
	localparam int CFG_FLOAT_BIT = 4;
	localparam int CFG_OFFSET_BIT = 5;
	localparam int CFG_EXP3_BIT = 6;
	localparam int CFG_DLY_LSB = 8;
	localparam int CFG_ORDER_LSB = 12;
	localparam int CFG_SHIFT_LSB = 16;
	localparam logic [31:0] CFG_MASK = 32'h003f_777f;
	localparam logic [31:0] CFG_RESET = 32'h002d_5000;
	localparam logic [2:0] SRC_TEST = 3'h4;
	localparam logic [5:0] SHIFT_NONE = 6'h2d;
	// CIC decimation limits
	localparam logic [16:0] DECIM_RESET = 17'h00004;
	localparam logic [16:0] DECIM_MIN = 17'h00004;
	localparam logic [16:0] DECIM_MAX_O5 = 17'h00200;
	localparam logic [16:0] DECIM_MAX_O4 = 17'h00800;
	localparam logic [16:0] DECIM_MAX_O3 = 17'h08000;
	localparam logic [16:0] DECIM_MAX_O12 = 17'h10000;
endpackage : ddc_pkg

// ### design/ddc_front_end.sv
// One channel front end: oscillator, complex mixer, barrel shifter, CIC.
// Assumes order and decimation arrive already clamped to legal ranges.
module ddc_front_end (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [31:0] freq,
	input wire logic [2:0] order,
	input wire logic [16:0] decim,
	input wire logic [5:0] shift,
	input wire logic [15:0] samp,
	input wire logic [2:0] samp_exp,
	input wire logic samp_en,
	output logic [23:0] out_i,
	output logic [23:0] out_q,
	output logic out_valid
);
	localparam int AW = ddc_pkg::ACC_W;

	typedef struct packed {
		logic [ddc_pkg::NCO_W-1:0] phase;
		logic [ddc_pkg::MIX_W-1:0] mix_i;
		logic [ddc_pkg::MIX_W-1:0] mix_q;
		logic mix_en;
		logic [5:0] mix_sh;
		logic [ddc_pkg::MAX_ORDER-1:0][AW-1:0] integ_i;
		logic [ddc_pkg::MAX_ORDER-1:0][AW-1:0] integ_q;
		logic [ddc_pkg::MAX_ORDER-1:0][AW-1:0] comb_i;
		logic [ddc_pkg::MAX_ORDER-1:0][AW-1:0] comb_q;
		logic [16:0] dcount;
		logic [23:0] out_i;
		logic [23:0] out_q;
		logic out_valid;
	} fe_s;

	fe_s r_reg, r_next;
	logic [6:0] sh_sum;
	logic signed [AW-1:0] xi, xq, vi, vq, ti, tq;

	// Coarse eight-point cosine over the top phase bits
	function automatic logic signed [7:0] cos_lut(input logic [2:0] p);
		case (p)
			3'h0: cos_lut = 8'sh7f;
			3'h1, 3'h7: cos_lut = 8'sh5a;
			3'h3, 3'h5: cos_lut = -8'sh5a;
			3'h4: cos_lut = -8'sh7f;
			default: cos_lut = 8'sh00;
		endcase
	endfunction : cos_lut

	always_comb
	begin
		r_next = r_reg;
		r_next.out_valid = 1'b0;
		sh_sum = 7'({1'b0, shift} + {4'h0, samp_exp});
		xi = '0;
		xq = '0;
		vi = '0;
		vq = '0;
		ti = '0;
		tq = '0;
		// RL4: qualifier travels with the sample
		r_next.mix_en = samp_en;
		if (samp_en)
		begin
			// RL15: 32-bit tuning word per channel
			r_next.phase = r_reg.phase + freq;
			// RL17: mixer feeds shifter then CIC
			r_next.mix_i = 24'($signed(samp) * cos_lut(r_reg.phase[31:29]));
			r_next.mix_q = 24'(-($signed(samp)
				* cos_lut(3'(r_reg.phase[31:29] - 3'h2))));
			// RL13: exponent gain applied in the shifter
			r_next.mix_sh = (sh_sum > {1'b0, ddc_pkg::SHIFT_NONE})
				? ddc_pkg::SHIFT_NONE : sh_sum[5:0];
		end
		if (r_reg.mix_en)
		begin
			// RL14: shift upward, 45 gives full scale
			xi = AW'($signed(r_reg.mix_i)) <<< r_reg.mix_sh;
			xq = AW'($signed(r_reg.mix_q)) <<< r_reg.mix_sh;
			r_next.integ_i[0] = r_reg.integ_i[0] + xi;
			r_next.integ_q[0] = r_reg.integ_q[0] + xq;
			for (int k = 1; k < ddc_pkg::MAX_ORDER; k++)
			begin
				r_next.integ_i[k] = r_reg.integ_i[k] + r_reg.integ_i[k-1];
				r_next.integ_q[k] = r_reg.integ_q[k] + r_reg.integ_q[k-1];
			end
			if (r_reg.dcount >= 17'(decim - 17'h1))
			begin
				r_next.dcount = '0;
				// RL16: order selects integrator tap and comb count
				vi = r_reg.integ_i[3'(order - 3'h1)];
				vq = r_reg.integ_q[3'(order - 3'h1)];
				for (int k = 0; k < ddc_pkg::MAX_ORDER; k++)
				begin
					if (k < int'(order))
					begin
						ti = vi - r_reg.comb_i[k];
						tq = vq - r_reg.comb_q[k];
						r_next.comb_i[k] = vi;
						r_next.comb_q[k] = vq;
						vi = ti;
						vq = tq;
					end
				end
				r_next.out_i = vi[AW-1 -: 24];
				r_next.out_q = vq[AW-1 -: 24];
				r_next.out_valid = 1'b1;
			end
			else
			begin
				r_next.dcount = 17'(r_reg.dcount + 17'h1);
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			r_reg <= '0;
			r_reg.mix_sh <= ddc_pkg::SHIFT_NONE;
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	assign out_i = r_reg.out_i;
	assign out_q = r_reg.out_q;
	assign out_valid = r_reg.out_valid;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_shift_cap: assert property (r_reg.mix_sh <= ddc_pkg::SHIFT_NONE) // RL14
		else $error("Shift above no-attenuation setting");
	a_output_spacing: assert property (out_valid |=> !out_valid) // RL16
		else $error("CIC output on two adjacent clocks");
	a_phase_hold: assert property (!samp_en |=> $stable(r_reg.phase)) // RL2
		else $error("Oscillator advanced without a sample");
endmodule : ddc_front_end

// ### design/ddc_input_frontend.sv
// Input select and format stage of a four-channel downconverter, with
// an APB register file, level detector and four channel front ends.
// Assumes all sample buses, qualifiers and syncs are synchronous to CLK.
//
// Summary of operation
// RL1: Each channel and the level detector pick one bus or the test value.
// RL2: Gated mode processes one sample per low qualifier, halts otherwise.
// RL3: Interpolated mode feeds zeros when the qualifier is high, every clock.
// RL4: Qualifier is pipelined with the data through every stage.
// RL5: Reset gives gated mode, inputs off; first sync enables them.
// RL6: Qualifier delayed zero to seven clocks loads the selection register.
// RL7: Undelayed qualifier loads the realignment register after selection.
// RL8: Source marks first slot; delay zero picks slot one, one slot two.
// RL9: Buses are 17 bits: 16-bit fixed or 14-bit mantissa plus exponent.
// RL10: Twos complement or offset binary, in fixed and floating modes.
// RL11: Fixed input: top bus bit weighs one, bit 1 weighs 2^-15.
// RL12: Floating input: low two or three bits are the exponent.
// RL13: Two-bit exponent gives 18dB, applied through the CIC shifter.
// RL14: Shift counts upward; 45 means no attenuation.
// RL15: Each channel oscillator has its own 32-bit tuning word.
// RL16: CIC order 1 to 5, decimation limits depend on the order.
// RL17: Each channel chains oscillator, mixer, shifter and CIC.
// RL18: Any bus may feed any or all channels at once.
// RL19: A level detector tracks the peak of a chosen input bus.
// RL20: All channels share one sample clock.
// RL21: Offset binary flips the mantissa sign bit before mixing.
module ddc_input_frontend (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [3:0][16:0] SAMPLE_BUS,
	input wire logic [3:0] INPUT_SAMPLE_QUALIFIER_N,
	input wire logic GLOBAL_SYNC_PULSE,
	input wire logic [3:0] CHANNEL_SYNC_PULSE,
	output logic [3:0][23:0] CH_I,
	output logic [3:0][23:0] CH_Q,
	output logic [3:0] CH_VALID
);
	localparam int NC = ddc_pkg::NUM_CH;

	typedef struct packed {
		logic [16:0] test_val;
		logic [2:0] lvl_src;
		logic [15:0] lvl_peak;
		logic [NC-1:0][31:0] ch_cfg;
		logic [NC-1:0][31:0] ch_freq;
		logic [NC-1:0][16:0] ch_decim;
		logic [NC-1:0] ch_enabled;
		logic [NC-1:0][ddc_pkg::HIST_W-1:0] qual_hist;
		logic [NC-1:0][16:0] sel_data;
		logic [NC-1:0][16:0] align_data;
		logic [NC-1:0] align_en;
		logic [31:0] prdata;
		logic pslverr;
	} top_s;

	top_s r_reg, r_next;

	logic apb_setup, apb_wr;
	logic ch_hit;
	logic [1:0] ch_sel;
	logic hit_test, hit_lvl_cfg, hit_lvl_peak;
	logic hit_cfg, hit_freq, hit_decim, hit_stat, hit_any;
	logic [NC-1:0][16:0] ch_bus;
	logic [NC-1:0] q_now;
	logic [NC-1:0][7:0] hist;
	logic [NC-1:0] tap;
	logic [NC-1:0][15:0] fe_samp;
	logic [NC-1:0][2:0] fe_exp;
	logic [NC-1:0] fe_en;
	logic [NC-1:0][2:0] fe_order;
	logic [NC-1:0][16:0] fe_decim;
	logic [2:0] src;
	logic [16:0] lvl_bus;
	logic lvl_q;
	logic [15:0] lvl_mag;
	logic [15:0] lvl_fix;

	// RL16: legal order and decimation per order
	function automatic logic [2:0] clamp_order(input logic [2:0] o);
		if (o == 3'h0)
			clamp_order = 3'h1;
		else if (o > 3'(ddc_pkg::MAX_ORDER))
			clamp_order = 3'(ddc_pkg::MAX_ORDER);
		else
			clamp_order = o;
	endfunction : clamp_order

	function automatic logic [16:0] clamp_decim(input logic [16:0] d,
		input logic [2:0] o);
		logic [16:0] top;
		case (o)
			3'h5: top = ddc_pkg::DECIM_MAX_O5;
			3'h4: top = ddc_pkg::DECIM_MAX_O4;
			3'h3: top = ddc_pkg::DECIM_MAX_O3;
			default: top = ddc_pkg::DECIM_MAX_O12;
		endcase
		if (d < ddc_pkg::DECIM_MIN)
			clamp_decim = ddc_pkg::DECIM_MIN;
		else if (d > top)
			clamp_decim = top;
		else
			clamp_decim = d;
	endfunction : clamp_decim

	// Decode one bus word into a left-aligned sample and an exponent
	function automatic logic [18:0] decode(input logic [16:0] b,
		input logic [31:0] cfg);
		logic [15:0] m;
		logic [2:0] e;
		if (cfg[ddc_pkg::CFG_FLOAT_BIT])
		begin
			// RL12: low bits are exponent, upper bits mantissa
			m = {b[16:3], 2'h0};
			e = cfg[ddc_pkg::CFG_EXP3_BIT] ? b[2:0] : {1'b0, b[1:0]};
		end
		else
		begin
			// RL11: top bus bit carries weight one
			m = b[16:1];
			e = 3'h0;
		end
		// RL21: offset binary to twos complement
		// RL10: coding selectable in both modes
		if (cfg[ddc_pkg::CFG_OFFSET_BIT])
			m[15] = ~m[15];
		decode = {m, e};
	endfunction : decode

	assign apb_setup = PSEL & ~PENABLE;
	assign apb_wr = PSEL & PENABLE & PWRITE;
	assign ch_sel = PADDR[5:4];
	assign ch_hit = (PADDR[11:6] == ddc_pkg::CH_BLOCK);
	assign hit_test = (PADDR == ddc_pkg::OFS_TEST);
	assign hit_lvl_cfg = (PADDR == ddc_pkg::OFS_LVL_CFG);
	assign hit_lvl_peak = (PADDR == ddc_pkg::OFS_LVL_PEAK);
	assign hit_cfg = ch_hit & (PADDR[3:0] == ddc_pkg::OFS_CH_CFG);
	assign hit_freq = ch_hit & (PADDR[3:0] == ddc_pkg::OFS_CH_FREQ);
	assign hit_decim = ch_hit & (PADDR[3:0] == ddc_pkg::OFS_CH_DECIM);
	assign hit_stat = ch_hit & (PADDR[3:0] == ddc_pkg::OFS_CH_STAT);
	assign hit_any = hit_test | hit_lvl_cfg | hit_lvl_peak | hit_cfg
		| hit_freq | hit_decim | hit_stat;

	always_comb
	begin
		r_next = r_reg;
		ch_bus = '0;
		q_now = '0;
		hist = '0;
		tap = '0;
		fe_samp = '0;
		fe_exp = '0;
		fe_en = '0;
		fe_order = '0;
		fe_decim = '0;
		src = '0;
		lvl_bus = '0;
		lvl_q = 1'b0;
		lvl_fix = '0;
		lvl_mag = '0;

		for (int c = 0; c < NC; c++)
		begin
			src = r_reg.ch_cfg[c][ddc_pkg::CFG_SRC_LSB +: 3];
			// RL1: bus or test value as source
			// RL18: every channel selects independently
			if (src == ddc_pkg::SRC_TEST)
			begin
				ch_bus[c] = r_reg.test_val;
				q_now[c] = r_reg.ch_enabled[c];
			end
			else if (src < ddc_pkg::SRC_TEST)
			begin
				ch_bus[c] = SAMPLE_BUS[src[1:0]];
				// RL5: qualifier ignored until a sync
				q_now[c] = ~INPUT_SAMPLE_QUALIFIER_N[src[1:0]]
					& r_reg.ch_enabled[c];
			end
			// RL6: programmable qualifier delay line
			hist[c] = {r_reg.qual_hist[c], q_now[c]};
			tap[c] = hist[c][r_reg.ch_cfg[c][ddc_pkg::CFG_DLY_LSB +: 3]];
			r_next.qual_hist[c] = hist[c][ddc_pkg::HIST_W-1:0];
			// RL8: delay picks the slot that many clocks after the marked one
			if (tap[c])
				r_next.sel_data[c] = ch_bus[c];
			// RL7: undelayed qualifier realigns the slot
			// RL4: qualifier registered beside its data
			r_next.align_en[c] = q_now[c];
			if (q_now[c])
				r_next.align_data[c] = r_reg.sel_data[c];
			// RL5: global or channel sync turns inputs on
			if (GLOBAL_SYNC_PULSE | CHANNEL_SYNC_PULSE[c])
				r_next.ch_enabled[c] = 1'b1;
			// RL9: 17-bit word into sample and exponent
			{fe_samp[c], fe_exp[c]} = decode(r_reg.align_data[c],
				r_reg.ch_cfg[c]);
			if (r_reg.ch_cfg[c][ddc_pkg::CFG_INTERP_BIT])
			begin
				// RL3: zero stuffing, processing every clock
				fe_en[c] = 1'b1;
				if (!r_reg.align_en[c])
				begin
					fe_samp[c] = '0;
					fe_exp[c] = '0;
				end
			end
			else
			begin
				// RL2: gated, one sample per qualifier
				fe_en[c] = r_reg.align_en[c];
			end
			fe_order[c] = clamp_order(
				r_reg.ch_cfg[c][ddc_pkg::CFG_ORDER_LSB +: 3]);
			fe_decim[c] = clamp_decim(r_reg.ch_decim[c], fe_order[c]);
		end

		// RL19: peak magnitude of the chosen bus
		if (r_reg.lvl_src == ddc_pkg::SRC_TEST)
		begin
			lvl_bus = r_reg.test_val;
			lvl_q = 1'b1;
		end
		else if (r_reg.lvl_src < ddc_pkg::SRC_TEST)
		begin
			lvl_bus = SAMPLE_BUS[r_reg.lvl_src[1:0]];
			lvl_q = ~INPUT_SAMPLE_QUALIFIER_N[r_reg.lvl_src[1:0]];
		end
		lvl_fix = lvl_bus[16:1];
		lvl_mag = lvl_fix[15] ? 16'(-lvl_fix) : lvl_fix;
		if (lvl_q && lvl_mag > r_reg.lvl_peak)
			r_next.lvl_peak = lvl_mag;

		// Read data is latched in the setup phase
		if (apb_setup)
		begin
			r_next.pslverr = ~hit_any;
			r_next.prdata = '0;
			if (hit_test)
				r_next.prdata = {15'h0000, r_reg.test_val};
			if (hit_lvl_cfg)
				r_next.prdata = {29'h00000000, r_reg.lvl_src};
			if (hit_lvl_peak)
				r_next.prdata = {16'h0000, r_reg.lvl_peak};
			if (hit_cfg)
				r_next.prdata = r_reg.ch_cfg[ch_sel];
			if (hit_freq)
				r_next.prdata = r_reg.ch_freq[ch_sel];
			if (hit_decim)
				r_next.prdata = {15'h0000, r_reg.ch_decim[ch_sel]};
			if (hit_stat)
				r_next.prdata = {30'h00000000, r_reg.align_en[ch_sel],
					r_reg.ch_enabled[ch_sel]};
		end

		if (apb_wr)
		begin
			if (hit_test)
				r_next.test_val = PWDATA[16:0];
			if (hit_lvl_cfg)
				r_next.lvl_src = PWDATA[2:0];
			// Clear loses to a sample arriving on the same clock
			if (hit_lvl_peak)
				r_next.lvl_peak = lvl_q ? lvl_mag : 16'h0000;
			if (hit_cfg)
				r_next.ch_cfg[ch_sel] = PWDATA & ddc_pkg::CFG_MASK;
			if (hit_freq)
				r_next.ch_freq[ch_sel] = PWDATA;
			if (hit_decim)
				r_next.ch_decim[ch_sel] = PWDATA[16:0];
		end
	end

	always_ff @(posedge CLK)
	begin
		if (!RESET_N)
		begin
			r_reg <= '0;
			r_reg.ch_cfg <= {NC{ddc_pkg::CFG_RESET}};
			r_reg.ch_decim <= {NC{ddc_pkg::DECIM_RESET}};
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	assign PRDATA = r_reg.prdata;
	assign PSLVERR = r_reg.pslverr & PSEL & PENABLE;
	assign PREADY = PSEL & PENABLE;

	for (genvar g = 0; g < NC; g++)
	begin : g_ch
		// RL17: per-channel processing chain
		// RL20: one shared sample clock
		ddc_front_end u_fe (
			.clk(CLK),
			.reset_n(RESET_N),
			.freq(r_reg.ch_freq[g]),
			.order(fe_order[g]),
			.decim(fe_decim[g]),
			.shift(r_reg.ch_cfg[g][ddc_pkg::CFG_SHIFT_LSB +: 6]),
			.samp(fe_samp[g]),
			.samp_exp(fe_exp[g]),
			.samp_en(fe_en[g]),
			.out_i(CH_I[g]),
			.out_q(CH_Q[g]),
			.out_valid(CH_VALID[g])
		);
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);

	sequence s_ch0_gated_sample;
		r_reg.ch_enabled[0] && !r_reg.ch_cfg[0][ddc_pkg::CFG_INTERP_BIT]
			&& q_now[0];
	endsequence

	sequence s_ch0_slot1;
		q_now[0] && r_reg.ch_cfg[0][ddc_pkg::CFG_DLY_LSB +: 3] == 3'h1
			&& !apb_wr ##1 !apb_wr;
	endsequence

	a_enable_by_sync: assert property ( // RL5
		!r_reg.ch_enabled[0] && GLOBAL_SYNC_PULSE |=> r_reg.ch_enabled[0])
		else $error("Sync did not enable channel 0");
	a_quiet_until_sync: assert property ( // RL5
		!r_reg.ch_enabled[0] |=> !r_reg.align_en[0])
		else $error("Channel 0 took a sample before sync");
	a_gated_take: assert property ( // RL2
		s_ch0_gated_sample ##1 !r_reg.ch_cfg[0][ddc_pkg::CFG_INTERP_BIT]
			|-> fe_en[0])
		else $error("Gated sample not passed on");
	a_gated_halt: assert property ( // RL2
		!r_reg.ch_cfg[0][ddc_pkg::CFG_INTERP_BIT] && !r_reg.align_en[0]
			|-> !fe_en[0])
		else $error("Gated channel ran without a sample");
	a_interp_zero: assert property ( // RL3
		r_reg.ch_cfg[0][ddc_pkg::CFG_INTERP_BIT] && !r_reg.align_en[0]
			|-> fe_en[0] && fe_samp[0] == 16'h0000)
		else $error("Interpolated gap not zero");
	a_slot_select: assert property ( // RL8
		s_ch0_slot1 |=> r_reg.sel_data[0] == $past(ch_bus[0]))
		else $error("Delay one did not pick the second slot");
	a_realign_load: assert property ( // RL7
		q_now[0] |=> r_reg.align_data[0] == $past(r_reg.sel_data[0]))
		else $error("Realignment register missed its load");
	a_offset_sign: assert property ( // RL21
		r_reg.ch_cfg[1][ddc_pkg::CFG_OFFSET_BIT] && r_reg.align_en[1]
			|-> fe_samp[1][15] == ~r_reg.align_data[1][16])
		else $error("Offset binary sign not inverted");
	a_peak_hold: assert property ( // RL19
		!(apb_wr && hit_lvl_peak) |=> r_reg.lvl_peak >= $past(r_reg.lvl_peak))
		else $error("Level peak fell without a clear");
endmodule : ddc_input_frontend

// ### dv/adc_source.sv
// Model of the converters that drive the four parallel sample buses.
// Assumes the bench picks the pattern; all changes follow a rising CLK.
module adc_source (
	input wire logic clk,
	input wire logic [1:0] mode,
	input wire logic [16:0] val,
	output logic [3:0][16:0] bus,
	output logic [3:0] qual_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] slot = 2'h0;
	initial
	begin
		bus = '0;
		qual_n = 4'hf;
	end
	always @(posedge clk)
	begin
		slot <= slot + 2'h1;
		bus[3:1] <= ~bus[3:1];
		qual_n[3:1] <= 3'h7;
		case (mode)
		2'h1:
		begin
			bus[0] <= val;
			qual_n[0] <= 1'b0;
		end
		2'h2:
		begin
			bus[0] <= (slot == 2'h0) ? val : ~val;
			qual_n[0] <= (slot != 2'h0);
		end
		default:
		begin
			bus[0] <= ~bus[0];
			qual_n[0] <= 1'b1;
		end
		endcase
	end
endmodule : adc_source

// ### dv/tb_top.sv
// Self-checking bench for the downconverter input stage.
// Assumes the converter model adc_source; APB waits are bounded only by the global timeout.
`define CHK(got, exp) \
	begin \
		checks++; \
		if ((got) !== (exp)) \
		begin \
			fails++; \
			$display("wrong value at %0t: got %h expected %h", $time, got, exp); \
		end \
	end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic gsync = 1'b0;
	logic [3:0] csync = 4'h0;
	logic [1:0] mode = 2'h0;
	logic [16:0] val = 17'h0;
	logic [3:0][16:0] bus;
	logic [3:0] qn;
	logic [3:0][23:0] ch_i;
	logic [3:0][23:0] ch_q;
	logic [3:0] ch_valid;
	logic [31:0] rd;
	logic err;
	int checks = 0;
	int fails = 0;
	int cycles = 0;
	int vcnt[4];
	logic [11:0] base;
	// Shift 35 offsets the 2^10 CIC gain of order 5 at decimation 4
	localparam logic [31:0] cfg_gain = ddc_pkg::CFG_RESET - 32'h000a_0000;
	adc_source i_adc_source (.clk(clk), .mode(mode), .val(val), .bus(bus),
		.qual_n(qn));
	ddc_input_frontend i_ddc_input_frontend (.CLK(clk), .RESET_N(rst_n),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .SAMPLE_BUS(bus), .INPUT_SAMPLE_QUALIFIER_N(qn),
		.GLOBAL_SYNC_PULSE(gsync), .CHANNEL_SYNC_PULSE(csync),
		.CH_I(ch_i), .CH_Q(ch_q), .CH_VALID(ch_valid));
	always #2 clk = ~clk;
	task summarize;
		if (fails == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize
	always @(posedge clk)
	begin
		cycles++;
		for (int c = 0; c < 4; c++)
			vcnt[c] += ch_valid[c];
		if (cycles == 20000)
		begin
			fails++;
			summarize();
		end
	end
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		`CHK(rd, exp)
	endtask : rchk
	// Counts valids over n clocks; results are read off the falling edge
	task run(input int n);
		@(negedge clk);
		vcnt = '{default: 0};
		repeat (n) @(negedge clk);
	endtask : run
	task src(input logic [1:0] m, input logic [16:0] v);
		@(posedge clk);
		mode <= m;
		val <= v;
	endtask : src
	initial
	begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		for (int c = 0; c < 4; c++)
		begin
			base = 12'(12'h040 + 12'h010 * c);
			rchk(base, ddc_pkg::CFG_RESET);
			rchk(base + 12'h004, 32'h0);
			rchk(base + 12'h008, {15'h0, ddc_pkg::DECIM_RESET});
			rchk(base + 12'h00c, 32'h0);
		end
		apb(1'b0, 12'h0fc, 32'h0);
		`CHK({err, rd}, 33'h1_0000_0000)
		apb(1'b1, 12'h0fc, 32'hffff_ffff);
		`CHK(err, 1'b1)
		apb(1'b1, 12'h070, 32'hffff_5fff);
		rchk(12'h070, 32'hffff_5fff & ddc_pkg::CFG_MASK);
		apb(1'b1, 12'h070, ddc_pkg::CFG_RESET);
		src(2'h1, 17'h10000);
		run(40);
		`CHK(vcnt[0] + vcnt[1] + vcnt[2] + vcnt[3], 0)
		@(posedge clk);
		csync <= 4'h4;
		@(posedge clk);
		csync <= 4'h0;
		apb(1'b0, 12'h06c, 32'h0);
		`CHK(rd[0], 1'b1)
		apb(1'b0, 12'h04c, 32'h0);
		`CHK(rd[0], 1'b0)
		@(posedge clk);
		gsync <= 1'b1;
		@(posedge clk);
		gsync <= 1'b0;
		apb(1'b1, 12'h050, ddc_pkg::CFG_RESET | 32'h20);
		apb(1'b1, 12'h060, ddc_pkg::CFG_RESET | 32'h2);
		apb(1'b1, 12'h074, 32'h4000_0000);
		apb(1'b1, 12'h040, cfg_gain);
		run(200);
		`CHK(vcnt[0] inside {[46:51]}, 1'b1)
		`CHK(vcnt[2], 0)
		`CHK(ch_i[1], 24'h0)
		`CHK(ch_i[0], 24'he04000)
		`CHK(ch_q[0], 24'h0)
		`CHK(ch_i[3] != ch_i[0], 1'b1)
		src(2'h0, 17'h0);
		run(8);
		run(100);
		`CHK(vcnt[0], 0)
		apb(1'b1, 12'h048, 32'h1);
		apb(1'b1, 12'h040, ddc_pkg::CFG_RESET | 32'h8);
		run(100);
		`CHK(vcnt[0] inside {[23:27]}, 1'b1)
		apb(1'b1, 12'h048, 32'h3e8);
		run(2100);
		`CHK(vcnt[0] inside {[3:5]}, 1'b1)
		apb(1'b1, 12'h048, 32'h4);
		apb(1'b1, 12'h040, cfg_gain | 32'h100);
		apb(1'b1, 12'h000, 32'h18000);
		apb(1'b1, 12'h060, cfg_gain | 32'h4);
		run(200);
		`CHK(vcnt[2] inside {[46:51]}, 1'b1)
		`CHK(ch_i[2], 24'hf02000)
		apb(1'b1, 12'h050, cfg_gain);
		src(2'h2, 17'h08000);
		run(300);
		`CHK(ch_i[1], 24'h0fe000)
		`CHK(ch_i[0][23], 1'b1)
		`CHK(ch_i[0] != ch_i[1], 1'b1)
		apb(1'b1, 12'h050, cfg_gain | 32'h10);
		// Shift 31 plus 3-bit exponent 6 equals channel 1's 35 plus 2
		apb(1'b1, 12'h060, 32'h001f_5050);
		src(2'h1, 17'h08006);
		run(200);
		`CHK(ch_i[1], 24'h3f8000)
		`CHK(ch_i[2], 24'h3f8000)
		src(2'h0, 17'h0);
		apb(1'b1, 12'h004, 32'h0);
		apb(1'b1, 12'h008, 32'h0);
		src(2'h1, 17'h18000);
		run(20);
		src(2'h0, 17'h0);
		run(5);
		rchk(12'h008, 32'h4000);
		apb(1'b1, 12'h008, 32'h0);
		rchk(12'h008, 32'h0);
		summarize();
	end
endmodule : tb_top
